/* File: hdl/left_adc_line_input_mix_map.vh */
`ifndef LEFT_ADC_LINE_INPUT_MIX_MAP_VH
`define LEFT_ADC_LINE_INPUT_MIX_MAP_VH

// ****************************************************************
// Register indices; the byte address is four times the index, except the status entry, which is a byte address.
// ****************************************************************
`define IDX_LEFT_LINE_ONE_TO_LEFT  8'h13
`define IDX_LEFT_LINE_TWO_TO_LEFT  8'h14
`define IDX_RIGHT_LINE_ONE_TO_LEFT 8'h15
`define ADDR_MIX_STATUS            8'h80

// ****************************************************************
// Field positions.
// ****************************************************************
`define WIRING_BIT                 7
`define LEVEL_MSB                  6
`define LEVEL_LSB                  3
`define BIAS_BIT                   2
`define POWER_BIT                  2

// ****************************************************************
// Reset values and writable-bit masks.
// ****************************************************************
`define RST_LEFT_LINE_ONE_TO_LEFT  8'h78
`define RST_LEFT_LINE_TWO_TO_LEFT  8'h78
`define RST_RIGHT_LINE_ONE_TO_LEFT 8'h78
`define WMASK_LEFT_LINE_ONE        8'hFF
`define WMASK_LEFT_LINE_TWO        8'hFC
`define WMASK_RIGHT_LINE_ONE       8'hF8

// ****************************************************************
// Level codes and bus responses.
// ****************************************************************
`define LEVEL_DISCONNECT           4'hF
`define LEVEL_MAX_FINE             4'h8
`define RESP_OKAY                  2'h0
`define RESP_SLVERR                2'h2

// ****************************************************************
// Address decoder selections.
// ****************************************************************
`define SEL_NONE                   3'h0
`define SEL_LEFT_LINE_ONE          3'h1
`define SEL_LEFT_LINE_TWO          3'h2
`define SEL_RIGHT_LINE_ONE         3'h3
`define SEL_STATUS                 3'h4

`endif

/* File: hdl/mix_level_decode.v */
`timescale 1ns/1ps
`default_nettype none

`include "left_adc_line_input_mix_map.vh"

// ****************************************************************
// Level code decoder for one line input of the left mix.
// ****************************************************************
module mix_level_decode (
	input  wire [3:0] level_code,
	input  wire       fine_steps,
	output reg        connected,
	output reg        reserved_code,
	output reg  [3:0] atten_steps
);

	// A fine input accepts every code up to eight; a coarse one only steps of four.
	// The attenuation in 1.5 dB steps equals the code itself for every connecting code; 1111 gives zero.
	always @* begin
		connected     = 1'b0;
		reserved_code = 1'b0;
		atten_steps   = 4'h0;
		if (level_code == `LEVEL_DISCONNECT) begin
			connected = 1'b0;
		end else if (fine_steps && (level_code <= `LEVEL_MAX_FINE)) begin
			connected   = 1'b1; // [RULE9] [RULE10]
			atten_steps = level_code;
		end else if (!fine_steps && (level_code[1:0] == 2'h0) && (level_code <= `LEVEL_MAX_FINE)) begin
			connected   = 1'b1; // [RULE3]
			atten_steps = level_code;
		end else begin
			// Reserved codes leave the input out of the mix rather than guess a gain.
			reserved_code = 1'b1;
		end
	end

endmodule

`default_nettype wire

/* File: hdl/left_adc_line_input_mix_regs.v */
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none

`include "left_adc_line_input_mix_map.vh"

// How it works
// RULE1 - Second left line bit 7 picks single-ended or differential wiring, resets 0.
// RULE2 - Software keeps second left line wiring equal in left and right registers.
// RULE3 - Second left line level: 0000 0 dB, 0100 -6, 1000 -12, 1111 off.
// RULE4 - Software never writes the reserved second left line level codes.
// RULE5 - Second left line bit 2 enables weak common-mode bias, resets 0.
// RULE6 - Reserved low bits of both mix registers read zero and ignore writes.
// RULE7 - First right line bit 7 picks single-ended or differential wiring, resets 0.
// RULE8 - Software keeps both copies of first right line wiring equal.
// RULE9 - First right line level steps -1.5 dB from 0000 to 1000; 1111 off.
// RULE10 - Any attenuation code connects first right line into the left mix.
// RULE11 - Software never writes codes 1001 to 1110 to first right line level.
// RULE12 - First left line bit 2 powers the left ADC channel up, resets 0.
// RULE13 - Writes take effect at once, reads return stored value, reset reloads.
module left_adc_line_input_mix_regs (
	input  wire        aclk,
	input  wire        aresetn,
	input  wire        ce,
	input  wire [7:0]  awaddr,
	input  wire        awvalid,
	output reg         awready,
	input  wire [31:0] wdata,
	input  wire [3:0]  wstrb,
	input  wire        wvalid,
	output reg         wready,
	output reg  [1:0]  bresp,
	output reg         bvalid,
	input  wire        bready,
	input  wire [7:0]  araddr,
	input  wire        arvalid,
	output reg         arready,
	output reg  [31:0] rdata,
	output reg  [1:0]  rresp,
	output reg         rvalid,
	input  wire        rready,
	output reg         second_left_line_input_wiring_style,
	output reg  [3:0]  second_left_line_input_level,
	output reg         second_left_line_input_connected,
	output reg  [3:0]  second_left_line_input_atten_steps,
	output reg         first_right_line_input_wiring_style,
	output reg  [3:0]  first_right_line_input_level,
	output reg         first_right_line_input_connected,
	output reg  [3:0]  first_right_line_input_atten_steps,
	output reg         left_unselected_bias_enable,
	output reg         left_adc_power_up
);

	// ****************************************************************
	// Address decode, shared by the write and the read path.
	// ****************************************************************
	function [2:0] reg_select;
		input [7:0] addr;
		begin
			// The index times four is ten bits wide, so the address is widened to match.
			if ({2'b00, addr} == {`IDX_LEFT_LINE_ONE_TO_LEFT, 2'b00}) begin
				reg_select = `SEL_LEFT_LINE_ONE;
			end else if ({2'b00, addr} == {`IDX_LEFT_LINE_TWO_TO_LEFT, 2'b00}) begin
				reg_select = `SEL_LEFT_LINE_TWO;
			end else if ({2'b00, addr} == {`IDX_RIGHT_LINE_ONE_TO_LEFT, 2'b00}) begin
				reg_select = `SEL_RIGHT_LINE_ONE;
			end else if (addr == `ADDR_MIX_STATUS) begin
				reg_select = `SEL_STATUS;
			end else begin
				reg_select = `SEL_NONE;
			end
		end
	endfunction

	// ****************************************************************
	// State.
	// ****************************************************************
	reg  [7:0]  left_line_one_reg;
	reg  [7:0]  left_line_two_reg;
	reg  [7:0]  right_line_one_reg;
	reg         aw_hold_reg;
	reg  [7:0]  aw_addr_reg;
	reg         w_hold_reg;
	reg  [7:0]  w_data_reg;
	reg         w_strb_reg;
	reg  [7:0]  left_line_one_next;
	reg  [7:0]  left_line_two_next;
	reg  [7:0]  right_line_one_next;
	reg         aw_hold_next;
	reg  [7:0]  aw_addr_next;
	reg         w_hold_next;
	reg  [7:0]  w_data_next;
	reg         w_strb_next;
	reg         bvalid_next;
	reg  [1:0]  bresp_next;
	reg         rvalid_next;
	reg  [31:0] rdata_next;
	reg  [1:0]  rresp_next;
	reg  [2:0]  wsel;
	reg  [2:0]  rsel;
	reg  [7:0]  status_byte;
	wire [7:0]  level_codes;
	wire [1:0]  dec_connected;
	wire [1:0]  dec_reserved;
	wire [7:0]  dec_steps;

	// ****************************************************************
	// Level decoders: index 0 is the second left line, 1 the first right line.
	// ****************************************************************
	assign level_codes = {right_line_one_reg[`LEVEL_MSB:`LEVEL_LSB], left_line_two_reg[`LEVEL_MSB:`LEVEL_LSB]};

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi = gi + 1) begin : g_dec
			mix_level_decode u_dec (
				.level_code    (level_codes[gi*4+3:gi*4]),
				.fine_steps    (gi == 1),
				.connected     (dec_connected[gi]),
				.reserved_code (dec_reserved[gi]),
				.atten_steps   (dec_steps[gi*4+3:gi*4])
			);
		end
	endgenerate

	// ****************************************************************
	// Bus next-state logic.
	// ****************************************************************

	// Address and data are latched independently so either may arrive first.
	// The response is raised only once both halves of the write are held.
	always @* begin
		left_line_one_next  = left_line_one_reg;
		left_line_two_next  = left_line_two_reg;
		right_line_one_next = right_line_one_reg;
		aw_hold_next        = aw_hold_reg;
		aw_addr_next        = aw_addr_reg;
		w_hold_next         = w_hold_reg;
		w_data_next         = w_data_reg;
		w_strb_next         = w_strb_reg;
		bvalid_next         = bvalid;
		bresp_next          = bresp;
		rvalid_next         = rvalid;
		rdata_next          = rdata;
		rresp_next          = rresp;
		wsel                = reg_select(aw_addr_reg);
		rsel                = reg_select(araddr);
		status_byte         = {4'h0, dec_reserved[1], dec_reserved[0], dec_connected[1], dec_connected[0]};
		if (awvalid && awready) begin
			aw_hold_next = 1'b1;
			aw_addr_next = awaddr;
		end
		if (wvalid && wready) begin
			w_hold_next = 1'b1;
			w_data_next = wdata[7:0];
			w_strb_next = wstrb[0];
		end
		if (bvalid && bready) begin
			bvalid_next = 1'b0;
		end
		if (aw_hold_reg && w_hold_reg && !bvalid) begin
			aw_hold_next = 1'b0;
			w_hold_next  = 1'b0;
			bvalid_next  = 1'b1;
			bresp_next   = (wsel == `SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
			// Only byte lane 0 carries register bits; a write without it stores nothing.
			if (w_strb_reg) begin
				case (wsel)
					`SEL_LEFT_LINE_ONE: begin
						left_line_one_next = w_data_reg & `WMASK_LEFT_LINE_ONE; // [RULE12] [RULE13]
					end
					`SEL_LEFT_LINE_TWO: begin
						// Masked bits keep their zero reset value forever.
						left_line_two_next = w_data_reg & `WMASK_LEFT_LINE_TWO; // [RULE6] [RULE13]
					end
					`SEL_RIGHT_LINE_ONE: begin
						right_line_one_next = w_data_reg & `WMASK_RIGHT_LINE_ONE; // [RULE6] [RULE13]
					end
					default: begin
						left_line_one_next = left_line_one_reg;
					end
				endcase
			end
		end
		if (rvalid && rready) begin
			rvalid_next = 1'b0;
		end
		if (arvalid && arready) begin
			rvalid_next = 1'b1;
			rresp_next  = (rsel == `SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
			case (rsel)
				`SEL_LEFT_LINE_ONE: begin
					rdata_next = {24'h000000, left_line_one_reg}; // [RULE13]
				end
				`SEL_LEFT_LINE_TWO: begin
					rdata_next = {24'h000000, left_line_two_reg}; // [RULE13]
				end
				`SEL_RIGHT_LINE_ONE: begin
					rdata_next = {24'h000000, right_line_one_reg}; // [RULE13]
				end
				`SEL_STATUS: begin
					rdata_next = {24'h000000, status_byte};
				end
				default: begin
					rdata_next = 32'h00000000;
				end
			endcase
		end
	end

	// ****************************************************************
	// Registers and outputs.
	// ****************************************************************

	// Decoded outputs are registered, so they trail the stored fields by one cycle.
	// Clock enable low freezes everything, including the bus handshake, but not reset.
	always @(posedge aclk) begin
		if (!aresetn) begin
			left_line_one_reg                   <= `RST_LEFT_LINE_ONE_TO_LEFT; // [RULE12] [RULE13]
			left_line_two_reg                   <= `RST_LEFT_LINE_TWO_TO_LEFT; // [RULE1] [RULE3] [RULE5] [RULE6]
			right_line_one_reg                  <= `RST_RIGHT_LINE_ONE_TO_LEFT; // [RULE7] [RULE9] [RULE6]
			aw_hold_reg                         <= 1'b0;
			aw_addr_reg                         <= 8'h00;
			w_hold_reg                          <= 1'b0;
			w_data_reg                          <= 8'h00;
			w_strb_reg                          <= 1'b0;
			awready                             <= 1'b0;
			wready                              <= 1'b0;
			bvalid                              <= 1'b0;
			bresp                               <= `RESP_OKAY;
			arready                             <= 1'b0;
			rvalid                              <= 1'b0;
			rdata                               <= 32'h00000000;
			rresp                               <= `RESP_OKAY;
			second_left_line_input_wiring_style <= 1'b0;
			second_left_line_input_level        <= `LEVEL_DISCONNECT;
			second_left_line_input_connected    <= 1'b0;
			second_left_line_input_atten_steps  <= 4'h0;
			first_right_line_input_wiring_style <= 1'b0;
			first_right_line_input_level        <= `LEVEL_DISCONNECT;
			first_right_line_input_connected    <= 1'b0;
			first_right_line_input_atten_steps  <= 4'h0;
			left_unselected_bias_enable         <= 1'b0;
			left_adc_power_up                   <= 1'b0;
		end else if (ce) begin
			left_line_one_reg                   <= left_line_one_next;
			left_line_two_reg                   <= left_line_two_next;
			right_line_one_reg                  <= right_line_one_next;
			aw_hold_reg                         <= aw_hold_next;
			aw_addr_reg                         <= aw_addr_next;
			w_hold_reg                          <= w_hold_next;
			w_data_reg                          <= w_data_next;
			w_strb_reg                          <= w_strb_next;
			awready                             <= !aw_hold_next && !bvalid_next;
			wready                              <= !w_hold_next && !bvalid_next;
			bvalid                              <= bvalid_next;
			bresp                               <= bresp_next;
			arready                             <= !rvalid_next;
			rvalid                              <= rvalid_next;
			rdata                               <= rdata_next;
			rresp                               <= rresp_next;
			second_left_line_input_wiring_style <= left_line_two_reg[`WIRING_BIT]; // [RULE1]
			second_left_line_input_level        <= left_line_two_reg[`LEVEL_MSB:`LEVEL_LSB]; // [RULE3]
			second_left_line_input_connected    <= dec_connected[0]; // [RULE3]
			second_left_line_input_atten_steps  <= dec_steps[3:0];
			first_right_line_input_wiring_style <= right_line_one_reg[`WIRING_BIT]; // [RULE7]
			first_right_line_input_level        <= right_line_one_reg[`LEVEL_MSB:`LEVEL_LSB]; // [RULE9]
			first_right_line_input_connected    <= dec_connected[1]; // [RULE10]
			first_right_line_input_atten_steps  <= dec_steps[7:4]; // [RULE9]
			left_unselected_bias_enable         <= left_line_two_reg[`BIAS_BIT]; // [RULE5]
			left_adc_power_up                   <= left_line_one_reg[`POWER_BIT]; // [RULE12]
		end
	end

endmodule

`default_nettype wire

/* File: dv/left_adc_line_input_mix_properties.sv */
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Bus timing and field decode checks for the left mix registers.
// ****************************************************************
module left_adc_line_input_mix_properties (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        ce,
	input wire logic [7:0]  awaddr,
	input wire logic        awvalid,
	input wire logic        awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0]  wstrb,
	input wire logic        wvalid,
	input wire logic        wready,
	input wire logic        bvalid,
	input wire logic [7:0]  araddr,
	input wire logic        arvalid,
	input wire logic        arready,
	input wire logic [31:0] rdata,
	input wire logic        rvalid,
	input wire logic [3:0]  second_left_line_input_level,
	input wire logic        second_left_line_input_connected,
	input wire logic [3:0]  second_left_line_input_atten_steps,
	input wire logic        first_right_line_input_wiring_style,
	input wire logic [3:0]  first_right_line_input_level,
	input wire logic        first_right_line_input_connected,
	input wire logic [3:0]  first_right_line_input_atten_steps
);
	logic [7:0] rd_addr_reg;

	// The read address is kept so the returned word can be judged later.
	always_ff @(posedge aclk) begin
		if (arvalid && arready && ce) begin
			rd_addr_reg <= araddr;
		end
	end

	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence ar_taken;
		arvalid && arready && ce;
	endsequence

	sequence wr_taken;
		awvalid && awready && wvalid && wready && ce;
	endsequence

	// Field outputs lag the stored word by one edge, so they are judged three edges on.
	sequence wr_to(logic [7:0] a);
		wr_taken ##0 (awaddr == a && wstrb[0]) ##1 ce[*3];
	endsequence

	fr_connect_a: assert property (first_right_line_input_connected == (first_right_line_input_level <= 4'h8))
		else $error("first right line connection does not follow its code");
	fr_steps_a: assert property (first_right_line_input_atten_steps ==
		(first_right_line_input_connected ? first_right_line_input_level : 4'h0))
		else $error("first right line steps do not follow its code");
	sl_connect_a: assert property (
		second_left_line_input_connected == (second_left_line_input_level inside {4'h0, 4'h4, 4'h8}))
		else $error("second left line connection does not follow its code");
	sl_steps_a: assert property (second_left_line_input_atten_steps ==
		(second_left_line_input_connected ? second_left_line_input_level : 4'h0))
		else $error("second left line steps do not follow its code");
	read_answer_a: assert property (ar_taken |=> rvalid && !arready)
		else $error("read answer missing one cycle after address");
	reserved_read_a: assert property (rvalid && rd_addr_reg == 8'h54 |-> rdata[2:0] == 3'h0 && rdata[31:8] == 24'h0)
		else $error("reserved bits of first right line word read nonzero");
	write_answer_a: assert property (wr_taken ##1 ce |=> bvalid)
		else $error("write response missing two cycles after handshake");
	fr_update_a: assert property (wr_to(8'h54) |-> first_right_line_input_level == $past(wdata[6:3], 3)
		&& first_right_line_input_wiring_style == $past(wdata[7], 3))
		else $error("first right line fields did not take the written word");
	sl_update_a: assert property (wr_to(8'h50) |-> second_left_line_input_level == $past(wdata[6:3], 3))
		else $error("second left line level did not take the written word");
endmodule

`default_nettype wire

/* File: dv/tb_left_adc_line_input_mix_regs.sv */
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Directed bench for the left mix register bank.
// ****************************************************************
module tb_left_adc_line_input_mix_regs;
	logic        aclk, aresetn, ce, awvalid, wvalid, bready, arvalid, rready;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp;
	logic        second_left_line_input_wiring_style, second_left_line_input_connected;
	logic        first_right_line_input_wiring_style, first_right_line_input_connected;
	logic        left_unselected_bias_enable, left_adc_power_up;
	logic [3:0]  second_left_line_input_level, second_left_line_input_atten_steps;
	logic [3:0]  first_right_line_input_level, first_right_line_input_atten_steps;
	int          mismatches, checked;

	left_adc_line_input_mix_regs left_adc_line_input_mix_regs_i (.aclk, .aresetn, .ce, .awaddr, .awvalid,
		.awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
		.rdata, .rresp, .rvalid, .rready, .second_left_line_input_wiring_style, .second_left_line_input_level,
		.second_left_line_input_connected, .second_left_line_input_atten_steps, .first_right_line_input_wiring_style,
		.first_right_line_input_level, .first_right_line_input_connected, .first_right_line_input_atten_steps,
		.left_unselected_bias_enable, .left_adc_power_up);

	// Both line inputs packed as wiring, level, connected and steps.
	wire [9:0] sl_fields = {second_left_line_input_wiring_style, second_left_line_input_level,
		second_left_line_input_connected, second_left_line_input_atten_steps};
	wire [9:0] fr_fields = {first_right_line_input_wiring_style, first_right_line_input_level,
		first_right_line_input_connected, first_right_line_input_atten_steps};

	// A 200 MHz clock.
	initial begin
		aclk = 1'b0;
		forever #2.5 aclk = ~aclk;
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Address and data are offered together; each is dropped once it is taken.
	// Each call lets one edge pass first, so a ready lowered by the last call is never raised in the same step.
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end while (awvalid || wvalid);
		do @(posedge aclk); while (!bvalid);
		bready <= 1'b0;
		chk({30'h0, bresp}, {30'h0, er});
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge aclk); while (!arready);
		arvalid <= 1'b0;
		do @(posedge aclk); while (!rvalid);
		rready <= 1'b0;
		chk(rdata, exp);
		chk({30'h0, rresp}, {30'h0, er});
	endtask

	task automatic t_reset();
		rd(8'h4C, 32'h78, 2'h0);
		rd(8'h50, 32'h78, 2'h0);
		rd(8'h54, 32'h78, 2'h0);
		chk({12'h0, sl_fields, fr_fields}, {12'h0, 10'h1E0, 10'h1E0});
		chk({30'h0, left_unselected_bias_enable, left_adc_power_up}, 32'h0);
		$display("reset test done");
	endtask

	// Every legal code of the first right line, wiring style flipping every second code.
	task automatic t_right();
		logic [3:0] c;
		logic       sty;
		for (int i = 0; i < 10; i++) begin
			c = (i < 9) ? i[3:0] : 4'hF;
			sty = i[1];
			// The right-channel copy of the wiring bit lies outside this bank; only legal codes are written.
			wr(8'h54, {24'h0, sty, c, 3'b000}, 4'h1, 2'h0);
			rd(8'h54, {24'h0, sty, c, 3'b000}, 2'h0);
			chk({22'h0, fr_fields}, {22'h0, sty, c, c != 4'hF, (c != 4'hF) ? c : 4'h0});
			rd(8'h80, {28'h0, 2'b00, c != 4'hF, 1'b0}, 2'h0);
		end
		$display("first right line test done");
	endtask

	task automatic t_left2();
		logic [3:0] codes [4];
		logic [3:0] c;
		codes = '{4'h0, 4'h4, 4'h8, 4'hF};
		for (int i = 0; i < 4; i++) begin
			c = codes[i];
			wr(8'h50, {24'h0, i[0], c, ~i[0], 2'b00}, 4'h1, 2'h0);
			rd(8'h50, {24'h0, i[0], c, ~i[0], 2'b00}, 2'h0);
			chk({22'h0, sl_fields}, {22'h0, i[0], c, c != 4'hF, (c != 4'hF) ? c : 4'h0});
			chk({31'h0, left_unselected_bias_enable}, {31'h0, ~i[0]});
		end
		$display("second left line test done");
	endtask

	task automatic t_power();
		logic [7:0] v;
		for (int i = 0; i < 2; i++) begin
			v = (i == 0) ? 8'h04 : 8'h00;
			wr(8'h4C, {24'h0, v}, 4'h1, 2'h0);
			rd(8'h4C, {24'h0, v}, 2'h0);
			chk({31'h0, left_adc_power_up}, {31'h0, v[2]});
		end
		$display("power test done");
	endtask

	// Unmapped places, reserved bits and a write with its strobe off.
	task automatic t_refuse();
		wr(8'h40, 32'hFF, 4'h1, 2'h2);
		rd(8'h40, 32'h0, 2'h2);
		wr(8'h54, 32'h7F, 4'h1, 2'h0);
		rd(8'h54, 32'h78, 2'h0);
		wr(8'h50, 32'h7B, 4'h1, 2'h0);
		rd(8'h50, 32'h78, 2'h0);
		wr(8'h54, 32'h80, 4'h0, 2'h0);
		rd(8'h54, 32'h78, 2'h0);
		wr(8'h80, 32'h0F, 4'h1, 2'h0);
		rd(8'h80, 32'h0, 2'h0);
		$display("refusal test done");
	endtask

	// With the clock enable low a fully offered write must not be taken.
	task automatic t_freeze();
		@(posedge aclk);
		ce <= 1'b0;
		awaddr <= 8'h4C;
		wdata <= 32'h00;
		wstrb <= 4'h1;
		{awvalid, wvalid, bready} <= 3'b111;
		repeat (4) @(posedge aclk);
		chk({30'h0, bvalid, left_adc_power_up}, 32'h1);
		{ce, awvalid, wvalid} <= 3'b100;
		rd(8'h4C, 32'h04, 2'h0);
		$display("freeze test done");
	endtask

	task automatic end_of_test();
		$display("compares %0d, mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// Cuts a hung handshake short; the whole run needs well under this.
	initial begin
		repeat (4000) @(posedge aclk);
		mismatches++;
		end_of_test();
	end

	// Main sequence, with a second reset once registers hold other values.
	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
		{awaddr, araddr, wdata, wstrb} = 52'h0;
		ce = 1'b1;
		mismatches = 0;
		checked = 0;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset();
		t_right();
		t_left2();
		t_power();
		t_refuse();
		wr(8'h4C, 32'h04, 4'h1, 2'h0);
		wr(8'h54, 32'h80, 4'h1, 2'h0);
		t_freeze();
		aresetn <= 1'b0;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset();
		end_of_test();
	end
endmodule

bind left_adc_line_input_mix_regs left_adc_line_input_mix_properties left_adc_line_input_mix_properties_i (
	.aclk, .aresetn, .ce, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bvalid, .araddr,
	.arvalid, .arready, .rdata, .rvalid, .second_left_line_input_level, .second_left_line_input_connected,
	.second_left_line_input_atten_steps, .first_right_line_input_wiring_style, .first_right_line_input_level,
	.first_right_line_input_connected, .first_right_line_input_atten_steps);

`default_nettype wire
